/* File: rtl/dual_port_ram.v */
// Synchronous pipelined dual-port RAM with AHB-Lite control and status registers.
`include "dual_port_ram_map.vh"
`default_nettype none

module dual_port_ram #(
  parameter AW = `RAM_ADDR_WIDTH,
  parameter LW = `RAM_LANE_WIDTH
) (
  input  wire            clock,                  // 200 MHz clock for both ports and the bus
  input  wire            resetn,                 // Asynchronous reset, active low
  input  wire            hsel,                   // AHB slave select
  input  wire [31:0]     haddr,                  // AHB address
  input  wire [1:0]      htrans,                 // AHB transfer type
  input  wire            hwrite,                 // AHB write
  input  wire [2:0]      hsize,                  // AHB size, word only
  input  wire [31:0]     hwdata,                 // AHB write data
  input  wire            hready,                 // AHB ready in
  output reg             hreadyout,              // AHB ready out
  output reg             hresp,                  // AHB response, always OKAY
  output reg  [31:0]     hrdata,                 // AHB read data
  input  wire [AW-1:0]   addr_a,                 // Port A external address
  input  wire            chip_select_n_a,        // Port A chip select, active low
  input  wire            chip_select_p_a,        // Port A chip select, active high
  input  wire            upper_lane_enable_n_a,  // Port A upper lane enable
  input  wire            lower_lane_enable_n_a,  // Port A lower lane enable
  input  wire            read_not_write_a,       // Port A high read, low write
  input  wire            address_load_strobe_n_a, // Port A address load
  input  wire            counter_advance_n_a,    // Port A counter advance
  input  wire            counter_clear_n_a,      // Port A counter clear
  input  wire            output_enable_n_a,      // Port A asynchronous output enable
  input  wire [2*LW-1:0] data_in_a,              // Port A data pin input
  output reg  [2*LW-1:0] data_out_a,             // Port A data pin output
  output wire [2*LW-1:0] data_oe_a,              // Port A data pin drive enable
  input  wire [AW-1:0]   addr_b,                 // Port B external address
  input  wire            chip_select_n_b,        // Port B chip select, active low
  input  wire            chip_select_p_b,        // Port B chip select, active high
  input  wire            upper_lane_enable_n_b,  // Port B upper lane enable
  input  wire            lower_lane_enable_n_b,  // Port B lower lane enable
  input  wire            read_not_write_b,       // Port B high read, low write
  input  wire            address_load_strobe_n_b, // Port B address load
  input  wire            counter_advance_n_b,    // Port B counter advance
  input  wire            counter_clear_n_b,      // Port B counter clear
  input  wire            output_enable_n_b,      // Port B asynchronous output enable
  input  wire [2*LW-1:0] data_in_b,              // Port B data pin input
  output reg  [2*LW-1:0] data_out_b,             // Port B data pin output
  output wire [2*LW-1:0] data_oe_b               // Port B data pin drive enable
);

  // Priority clear, load, advance, hold. Advancing exposes count+1 in the same cycle.
  function [AW-1:0] pick_address;
    input          clear_n;
    input          load_n;
    input          advance_n;
    input [AW-1:0] external;
    input [AW-1:0] count;
    begin
      if (!clear_n) begin
        pick_address = {AW{1'b0}};
      end else if (!load_n) begin
        pick_address = external;
      end else if (!advance_n) begin
        pick_address = count + {{(AW-1){1'b0}}, 1'b1};
      end else begin
        pick_address = count;
      end
    end
  endfunction

  wire [1:0] cs_n  = {chip_select_n_b, chip_select_n_a};
  wire [1:0] cs_p  = {chip_select_p_b, chip_select_p_a};
  wire [1:0] up_n  = {upper_lane_enable_n_b, upper_lane_enable_n_a};
  wire [1:0] lo_n  = {lower_lane_enable_n_b, lower_lane_enable_n_a};
  wire [1:0] rnw   = {read_not_write_b, read_not_write_a};
  wire [1:0] chip_on = ~cs_n & cs_p;
  wire [1:0] desel = ~chip_on | (up_n & lo_n);

  reg  [`RAM_CTRL_INHIBIT_W-1:0] write_inhibit;
  reg  [AW-1:0]   count_a;
  reg  [AW-1:0]   count_b;
  reg  [1:0]      wake_a;
  reg  [1:0]      wake_b;
  reg  [1:0]      stage_lanes_a;
  reg  [1:0]      stage_lanes_b;
  reg  [1:0]      drive_a;
  reg  [1:0]      drive_b;
  wire [AW-1:0]   int_addr_a = pick_address(counter_clear_n_a, address_load_strobe_n_a,
                                            counter_advance_n_a, addr_a, count_a);
  wire [AW-1:0]   int_addr_b = pick_address(counter_clear_n_b, address_load_strobe_n_b,
                                            counter_advance_n_b, addr_b, count_b);
  wire [1:0]      lanes_a = {~up_n[0], ~lo_n[0]} & {2{chip_on[0]}};
  wire [1:0]      lanes_b = {~up_n[1], ~lo_n[1]} & {2{chip_on[1]}};
  wire [1:0]      wen_a = lanes_a & {2{~rnw[0] & ~write_inhibit[0]}};
  wire [1:0]      wen_b = lanes_b & {2{~rnw[1] & ~write_inhibit[1]}};
  wire [2*LW-1:0] rdata_a;
  wire [2*LW-1:0] rdata_b;

  // Both ports share one clock, so their edges coincide: the minimum-offset case
  // always applies and cross-port data always lags by one cycle here.
  dual_port_ram_array #(
    .AW (AW),
    .LW (LW)
  ) u_array (
    .clock   (clock),
    .addr_a  (int_addr_a),
    .wen_a   (wen_a),
    .wdata_a (data_in_a),
    .rdata_a (rdata_a),
    .addr_b  (int_addr_b),
    .wen_b   (wen_b),
    .wdata_b (data_in_b),
    .rdata_b (rdata_b)
  );

  // Wake counters saturate at two selected edges after any deselect.
  wire [1:0] next_wake_a = desel[0] ? 2'h0 : (wake_a == `RAM_WAKE_CYCLES) ? wake_a : wake_a + 2'h1;
  wire [1:0] next_wake_b = desel[1] ? 2'h0 : (wake_b == `RAM_WAKE_CYCLES) ? wake_b : wake_b + 2'h1;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_a       <= {AW{1'b0}};
      count_b       <= {AW{1'b0}};
      wake_a        <= 2'h0;
      wake_b        <= 2'h0;
      stage_lanes_a <= 2'h0;
      stage_lanes_b <= 2'h0;
      drive_a       <= 2'h0;
      drive_b       <= 2'h0;
      data_out_a    <= {(2*LW){1'b0}};
      data_out_b    <= {(2*LW){1'b0}};
    end else begin
      count_a       <= int_addr_a;
      count_b       <= int_addr_b;
      wake_a        <= next_wake_a;
      wake_b        <= next_wake_b;
      stage_lanes_a <= lanes_a & {2{rnw[0]}};
      stage_lanes_b <= lanes_b & {2{rnw[1]}};
      // Drive lanes come from the previous cycle's read controls, cleared by a deselect in this cycle.
      drive_a    <= (desel[0] || wake_a == 2'h0) ? 2'h0 : stage_lanes_a;
      drive_b    <= (desel[1] || wake_b == 2'h0) ? 2'h0 : stage_lanes_b;
      data_out_a <= rdata_a;
      data_out_b <= rdata_b;
    end
  end

  // The output enable bypasses the pipeline so the pins can float at any moment.
  assign data_oe_a = {{LW{drive_a[1] & ~output_enable_n_a}},
                      {LW{drive_a[0] & ~output_enable_n_a}}};
  assign data_oe_b = {{LW{drive_b[1] & ~output_enable_n_b}},
                      {LW{drive_b[0] & ~output_enable_n_b}}};

  // AHB-Lite slave: zero wait states, read data registered at the address phase.
  reg                          wr_pending;
  reg [`RAM_OFFSET_WIDTH-1:0]  wr_offset;
  wire                         take = hsel & htrans[1] & hready;
  wire [`RAM_OFFSET_WIDTH-1:0] offset = haddr[`RAM_OFFSET_WIDTH-1:0];

  function [31:0] status_word;
    input [AW-1:0] count;
    input [1:0]    wake;
    input [1:0]    drive;
    begin
      status_word = 32'h0000_0000;
      status_word[`RAM_STATUS_ADDR_LSB +: AW] = count;
      status_word[`RAM_STATUS_WAKE_LSB +: 2]  = wake;
      status_word[`RAM_STATUS_DRIVE_LSB +: 2] = drive;
    end
  endfunction

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
      hrdata        <= 32'h0000_0000;
      wr_pending    <= 1'b0;
      wr_offset     <= {`RAM_OFFSET_WIDTH{1'b0}};
      write_inhibit <= `RAM_CTRL_RESET;
    end else begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      wr_pending <= take & hwrite;
      wr_offset  <= offset;
      if (wr_pending && wr_offset == `RAM_CTRL_OFFSET) begin
        write_inhibit <= hwdata[`RAM_CTRL_INHIBIT_LSB +: `RAM_CTRL_INHIBIT_W];
      end
      if (take && !hwrite) begin
        case (offset)
          `RAM_CTRL_OFFSET: begin
            hrdata <= {30'h0000_0000, write_inhibit};
          end
          `RAM_STATUS_A_OFFSET: begin
            hrdata <= status_word(count_a, wake_a, drive_a);
          end
          `RAM_STATUS_B_OFFSET: begin
            hrdata <= status_word(count_b, wake_b, drive_b);
          end
          default: begin
            hrdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

/* File: rtl/dual_port_ram_map.vh */
// Register offsets, field positions and reset values for the dual-port RAM block.
`ifndef DUAL_PORT_RAM_MAP_VH
`define DUAL_PORT_RAM_MAP_VH

`define RAM_OFFSET_WIDTH     12
`define RAM_CTRL_OFFSET      12'h000
`define RAM_STATUS_A_OFFSET  12'h004
`define RAM_STATUS_B_OFFSET  12'h008

`define RAM_CTRL_INHIBIT_LSB 0
`define RAM_CTRL_INHIBIT_W   2
`define RAM_CTRL_RESET       2'h0

`define RAM_STATUS_ADDR_LSB  0
`define RAM_STATUS_WAKE_LSB  16
`define RAM_STATUS_DRIVE_LSB 18

`define RAM_ADDR_WIDTH       16
`define RAM_LANE_WIDTH       9
`define RAM_WAKE_CYCLES      2'h2

`endif

/* File: rtl/dual_port_ram_array.v */
// Two-port storage array with per-lane write enables and registered read data.
`default_nettype none

module dual_port_ram_array #(
  parameter AW = 16,
  parameter LW = 9
) (
  input  wire            clock,    // Common clock
  input  wire [AW-1:0]   addr_a,   // Port A internal address
  input  wire [1:0]      wen_a,    // Port A lane write enables, bit 1 upper
  input  wire [2*LW-1:0] wdata_a,  // Port A write data
  output reg  [2*LW-1:0] rdata_a,  // Port A read data, registered
  input  wire [AW-1:0]   addr_b,   // Port B internal address
  input  wire [1:0]      wen_b,    // Port B lane write enables, bit 1 upper
  input  wire [2*LW-1:0] wdata_b,  // Port B write data
  output reg  [2*LW-1:0] rdata_b   // Port B read data, registered
);

  reg [LW-1:0] mem_lo [0:(1<<AW)-1];
  reg [LW-1:0] mem_hi [0:(1<<AW)-1];

  // Reads return the contents before this edge's writes, so a word written on one
  // port shows on the other port one cycle later. Port B wins a same-word collision.
  always @(posedge clock) begin
    rdata_a <= {mem_hi[addr_a], mem_lo[addr_a]};
    rdata_b <= {mem_hi[addr_b], mem_lo[addr_b]};
    if (wen_a[0]) begin
      mem_lo[addr_a] <= wdata_a[LW-1:0];
    end
    if (wen_a[1]) begin
      mem_hi[addr_a] <= wdata_a[2*LW-1:LW];
    end
    if (wen_b[0]) begin
      mem_lo[addr_b] <= wdata_b[LW-1:0];
    end
    if (wen_b[1]) begin
      mem_hi[addr_b] <= wdata_b[2*LW-1:LW];
    end
  end

endmodule

`default_nettype wire

/* File: sim/dual_port_ram_sva.sv */
// Assertions on the port a data outputs of the dual-port RAM.
`default_nettype none
module dual_port_ram_sva #(
  parameter LW = 9
) (
  input wire logic            clock,                   // Clock
  input wire logic            resetn,                  // Reset, active low
  input wire logic            chip_select_n_a,         // Select, active low
  input wire logic            chip_select_p_a,         // Select, active high
  input wire logic            upper_lane_enable_n_a,   // Upper lane enable
  input wire logic            lower_lane_enable_n_a,   // Lower lane enable
  input wire logic            read_not_write_a,        // Port a read
  input wire logic            read_not_write_b,        // Port b read
  input wire logic            address_load_strobe_n_a, // Address load
  input wire logic            counter_advance_n_a,     // Counter advance
  input wire logic            counter_clear_n_a,       // Counter clear
  input wire logic            output_enable_n_a,       // Output enable
  input wire logic [2*LW-1:0] data_out_a,              // Read data
  input wire logic [2*LW-1:0] data_oe_a                // Lane drive
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire logic sel_a;
  wire logic rd_ab;
  assign sel_a = !chip_select_n_a && chip_select_p_a && !upper_lane_enable_n_a
                 && !lower_lane_enable_n_a;
  assign rd_ab = read_not_write_a && read_not_write_b;
  a_csn_float: assert property (chip_select_n_a |=> data_oe_a == '0)
    else $error("drive stayed on after deselect");
  a_csp_float: assert property (!chip_select_p_a |=> data_oe_a == '0)
    else $error("drive stayed on after high select dropped");
  a_lanes_float: assert property ((upper_lane_enable_n_a && lower_lane_enable_n_a) [*2]
    |=> data_oe_a == '0)
    else $error("drive on with both lanes off");
  a_upper_gate: assert property (upper_lane_enable_n_a [*2]
    |=> data_oe_a[2*LW-1:LW] == '0)
    else $error("upper lane driven while disabled");
  a_lower_gate: assert property (lower_lane_enable_n_a [*2] |=> data_oe_a[LW-1:0] == '0)
    else $error("lower lane driven while disabled");
  a_oe_async: assert property (output_enable_n_a |-> data_oe_a == '0)
    else $error("drive on while output enable off");
  // The edge on which reset lets go is not a selected edge for the wake count.
  a_drive_on: assert property ((resetn && sel_a && read_not_write_a) [*2]
    |=> output_enable_n_a || data_oe_a == '1)
    else $error("no drive after two selected reads");
  a_hold_stable: assert property (rd_ab ##1 (rd_ab && address_load_strobe_n_a
    && counter_advance_n_a && counter_clear_n_a) |=> ##1 $stable(data_out_a))
    else $error("read data moved while address held");
endmodule
bind dual_port_ram dual_port_ram_sva #(.LW(LW)) u_sva (.clock, .resetn, .chip_select_n_a,
  .chip_select_p_a, .upper_lane_enable_n_a, .lower_lane_enable_n_a, .read_not_write_a,
  .read_not_write_b, .address_load_strobe_n_a, .counter_advance_n_a, .counter_clear_n_a,
  .output_enable_n_a, .data_out_a, .data_oe_a);
`default_nettype wire

/* File: sim/ram_port_host.sv */
// Behavioural host controller driving one RAM port, one request per clock.
`default_nettype none
module ram_port_host (
  input  wire logic        clock,    // Port clock
  input  wire logic [17:0] data_out, // Device read data
  input  wire logic [17:0] data_oe,  // Device lane drive
  output var  logic [15:0] addr,     // Address
  output var  logic        cs_n,     // Select, active low
  output var  logic        cs_p,     // Select, active high
  output var  logic [1:0]  lane_n,   // Upper and lower lane enables
  output var  logic        rnw,      // High read, low write
  output var  logic [2:0]  ctl_n,    // Load, advance and clear, active low
  output var  logic        oe_n,     // Output enable, active low
  output wire logic [17:0] data_in   // Wire level seen by the device
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [17:0] wdata;
  // A released lane shows the inverse of its last value so a float never reads as data.
  assign data_in = rnw ? data_out ^ ~data_oe : wdata;
  initial begin
    {addr, lane_n, wdata, cs_n, oe_n} = '0;
    {cs_p, rnw} = 2'h3;
    ctl_n = 3'h3;
  end
  task automatic op(input logic w, input logic [15:0] a, input logic [17:0] d,
                    input logic [1:0] ln = 2'h0, input logic [2:0] c = 3'h3,
                    input logic [1:0] sel = 2'h1);
    @(posedge clock);
    {cs_n, cs_p} <= sel;
    {addr, wdata, lane_n, ctl_n, rnw} <= {a, d, ln, c, ~w};
  endtask
endmodule
`default_nettype wire

/* File: sim/dual_port_ram_test.sv */
// Self-checking bench for the dual-port RAM ports and its register bus.
`default_nettype none
module dual_port_ram_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic w; logic [15:0] a; logic [17:0] d; logic [1:0] ln;} row_t;
  logic        clock = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r;
  wire         hreadyout, hresp, cn_a, cn_b, cp_a, cp_b, rw_a, rw_b, on_a, on_b;
  wire  [31:0] hrdata;
  wire  [15:0] ad_a, ad_b;
  wire  [17:0] di_a, di_b, do_a, do_b, oe_a, oe_b;
  wire  [2:0]  ct_a, ct_b;
  wire  [1:0]  ln_a, ln_b;
  int          n_fail = 0, compares = 0;
  row_t        rows [8] = '{'{1, 16'h0010, 18'h3FFFF, 0}, '{1, 16'h0010, 18'h00000, 1},
    '{1, 16'hFFFF, 18'h2A5A5, 0}, '{0, 16'h0010, 18'h001FF, 0}, '{1, 16'hFFFF, 18'h15A5A, 2},
    '{0, 16'hFFFF, 18'h2A45A, 1}, '{0, 16'hFFFF, 18'h2A45A, 2}, '{0, 16'hFFFF, 18'h2A45A, 3}};
  always #2.5 clock = ~clock;
  dual_port_ram u_dut (.clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .addr_a(ad_a),
    .chip_select_n_a(cn_a), .chip_select_p_a(cp_a), .upper_lane_enable_n_a(ln_a[1]),
    .lower_lane_enable_n_a(ln_a[0]), .read_not_write_a(rw_a), .address_load_strobe_n_a(ct_a[2]),
    .counter_advance_n_a(ct_a[1]), .counter_clear_n_a(ct_a[0]), .output_enable_n_a(on_a),
    .data_in_a(di_a), .data_out_a(do_a), .data_oe_a(oe_a), .addr_b(ad_b),
    .chip_select_n_b(cn_b), .chip_select_p_b(cp_b), .upper_lane_enable_n_b(ln_b[1]),
    .lower_lane_enable_n_b(ln_b[0]), .read_not_write_b(rw_b), .address_load_strobe_n_b(ct_b[2]),
    .counter_advance_n_b(ct_b[1]), .counter_clear_n_b(ct_b[0]), .output_enable_n_b(on_b),
    .data_in_b(di_b), .data_out_b(do_b), .data_oe_b(oe_b));
  ram_port_host u_host_a (.clock(clock), .data_out(do_a), .data_oe(oe_a), .addr(ad_a),
    .cs_n(cn_a), .cs_p(cp_a), .lane_n(ln_a), .rnw(rw_a), .ctl_n(ct_a), .oe_n(on_a),
    .data_in(di_a));
  ram_port_host u_host_b (.clock(clock), .data_out(do_b), .data_oe(oe_b), .addr(ad_b),
    .cs_n(cn_b), .cs_p(cp_b), .lane_n(ln_b), .rnw(rw_b), .ctl_n(ct_b), .oe_n(on_b),
    .data_in(di_b));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic test_done;
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Bounded wait for hready at a rising edge; a hang ends the run as a failure.
  task automatic wait_rdy;
    int i;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      test_done();
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, w};
    wait_rdy();
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    wait_rdy();
    r = hrdata;
  endtask
  task automatic rd_a(input logic [15:0] a, input logic [17:0] d, input logic [1:0] ln);
    logic [17:0] m;
    m = {{9{~ln[1]}}, {9{~ln[0]}}};
    repeat (3) u_host_a.op(1'b0, a, 18'h0, ln);
    #1;
    chk("port a data", {14'h0, d & m}, {14'h0, do_a & oe_a});
  endtask
  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    ahb(1'b0, 32'h0, 32'h0);
    chk("control reset", 32'h0, r);
    chk("bus answer", 32'h2, {30'h0, hreadyout, hresp});
    ahb(1'b1, 32'h0, 32'h3);
    ahb(1'b0, 32'h0, 32'h0);
    chk("control", 32'h3, r);
    ahb(1'b0, 32'hC, 32'h0);
    chk("unmapped", 32'h0, r);
    ahb(1'b1, 32'h0, 32'h0);
    foreach (rows[i]) begin
      if (rows[i].w) begin
        u_host_a.op(1'b1, rows[i].a, rows[i].d, rows[i].ln);
      end else begin
        rd_a(rows[i].a, rows[i].d, rows[i].ln);
      end
    end
    u_host_a.op(1'b1, 16'h0020, 18'h11111);
    fork
      u_host_a.op(1'b0, 16'h0020, 18'h0);
      u_host_b.op(1'b1, 16'h0020, 18'h22222);
    join
    fork
      u_host_a.op(1'b0, 16'h0020, 18'h0);
      u_host_b.op(1'b0, 16'h0020, 18'h0);
    join
    u_host_a.op(1'b0, 16'h0020, 18'h0);
    #1 chk("same edge read", 32'h11111, {14'h0, do_a});
    u_host_a.op(1'b0, 16'h0020, 18'h0);
    #1 chk("next edge read", 32'h22222, {14'h0, do_a});
    chk("port b data", 32'h22222, {14'h0, do_b & oe_b});
    ahb(1'b1, 32'h0, 32'h1);
    u_host_a.op(1'b1, 16'h0020, 18'h0);
    u_host_a.op(1'b0, 16'h0020, 18'h0);
    ahb(1'b1, 32'h0, 32'h0);
    rd_a(16'h0020, 18'h22222, 2'h0);
    u_host_a.op(1'b0, 16'h5555, 18'h0, 2'h0, 3'h2);
    u_host_a.op(1'b0, 16'h5555, 18'h0, 2'h0, 3'h5);
    u_host_a.op(1'b0, 16'h5555, 18'h0, 2'h0, 3'h7);
    ahb(1'b0, 32'h4, 32'h0);
    chk("cleared then advanced", 32'h1, {16'h0, r[15:0]});
    u_host_a.op(1'b0, 16'hBEEF, 18'h0);
    u_host_a.op(1'b0, 16'h0000, 18'h0, 2'h0, 3'h7);
    ahb(1'b0, 32'h4, 32'h0);
    chk("loaded address", 32'hBEEF, {16'h0, r[15:0]});
    ahb(1'b0, 32'h8, 32'h0);
    chk("port b status", 32'h000E_0020, r);
    u_host_a.op(1'b0, 16'h0020, 18'h0, 2'h0, 3'h3, 2'h3);
    u_host_a.op(1'b0, 16'h0020, 18'h0, 2'h0, 3'h3, 2'h0);
    #1 chk("deselected drive", 32'h0, {14'h0, oe_a});
    rd_a(16'h0020, 18'h22222, 2'h0);
    u_host_a.oe_n = 1'b1;
    #1 chk("output enable off", 32'h0, {14'h0, oe_a});
    u_host_a.oe_n = 1'b0;
    u_host_a.op(1'b0, 16'h0020, 18'h0, 2'h0, 3'h3, 2'h3);
    u_host_a.op(1'b1, 16'h0020, 18'h12345);
    rd_a(16'h0020, 18'h12345, 2'h0);
    test_done();
  end
endmodule
`default_nettype wire
